// >>> ccs_regs.svh
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH
// ----------------------------------------
// register addresses, first byte bits 6:3
// ----------------------------------------
`define CCS_ADDR_CTRL    4'h0
`define CCS_ADDR_ILR     4'h1
`define CCS_ADDR_LDR     4'h2
`define CCS_ADDR_RXGAIN  4'h4
`define CCS_ADDR_TXGAIN  4'h5
`define CCS_ADDR_RXSLOT  4'h9
`define CCS_ADDR_TXSLOT  4'hA
// ----------------------------------------
// reset values
// ----------------------------------------
`define CCS_CTRL_RST     8'h09
`define CCS_ZERO_RST     8'h00
`define CCS_SYNC_RST     14'h0002
`define CCS_POS_START    9'h1FF
// ----------------------------------------
// field positions
// ----------------------------------------
`define CCS_B1_PWR       7
`define CCS_B1_RD        2
`define CCS_B1_TWO       1
`define CCS_CT_LAW       5
`define CCS_CT_INV       4
`define CCS_CT_TIM       3
`define CCS_CT_DL        2
`define CCS_CT_AL        1
`define CCS_CT_PP        0
`define CCS_SL_EN        7
`define CCS_SL_PS        6
`define CCS_LATCH_MASK   8'hFC
// ----------------------------------------
// synchroniser lanes
// ----------------------------------------
`define CCS_SY_CTRL_CLOCK      0
`define CCS_SY_CS        1
`define CCS_SY_CI        2
`define CCS_SY_BCLK      3
`define CCS_SY_FSX       4
`define CCS_SY_FSR       5
`define CCS_SY_DR0       6
`define CCS_SY_DR1       7
// ----------------------------------------
// counts and codes
// ----------------------------------------
`define CCS_BIT_FIRST    3'h0
`define CCS_BIT_LAST     3'h7
`define CCS_FRAME_WAIT   2'h2
`define CCS_DIV_512K     10'h040
`define CCS_DIV_1M5      10'h0C0
`define CCS_DIV_2M0      10'h100
`define CCS_DIV_4M0      10'h200
`define CCS_MU_POS       8'h80
`define CCS_MU_NEG       8'h00
`define CCS_AI_POS       8'hAA
`define CCS_AI_NEG       8'h2A
`define CCS_AN_POS       8'hFF
`define CCS_AN_NEG       8'h7F
`endif

// >>> ccs_pkg.sv
package ccs_pkg;
    typedef enum logic {CP_BYTE1, CP_BYTE2} ccs_cp_state_t;
endpackage : ccs_pkg

// >>> ccs_codec_config.sv
`include "ccs_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module ccs_codec_config (
    input  wire logic       I_CLK,
    input  wire logic       I_RST_N,
    input  wire logic       I_CTRL_CLOCK,
    input  wire logic       I_CS_N,
    input  wire logic       I_CI,
    output logic            O_CO,
    output logic            O_CO_OE,
    input  wire logic       I_BCLK,
    input  wire logic       I_TX_FRAME_SYNC,
    input  wire logic       I_RX_FRAME_SYNC,
    input  wire logic       I_RX_PCM_IN_0,
    input  wire logic       I_RX_PCM_IN_1,
    output logic            O_TX_PCM_OUT_0,
    output logic            O_TX_PCM_OUT_1,
    output logic            O_TX_PCM_OE_0,
    output logic            O_TX_PCM_OE_1,
    input  wire logic [5:0] I_LATCH_PIN,
    output logic      [5:0] O_LATCH_PIN,
    output logic      [5:0] O_LATCH_OE,
    input  wire logic [7:0] I_TX_CODE,
    output logic      [7:0] O_RX_CODE,
    output logic            O_RX_CODE_VALID,
    output logic            O_SLEEP_STATE,
    output logic            O_AMP_ON,
    output logic      [9:0] O_MCLK_DIV,
    output logic            O_LAW_A,
    output logic            O_EVEN_INVERT,
    output logic            O_TIMING_DELAYED,
    output logic            O_LOOP_DIGITAL,
    output logic            O_LOOP_WAVE_PATH,
    output logic            O_RX_ANALOG_MUTE,
    output logic      [7:0] O_TX_GAIN,
    output logic      [7:0] O_FULL_POS,
    output logic      [7:0] O_FULL_NEG
);
    // ----------------------------------------
    // slot match
    // ----------------------------------------
    function automatic logic slot_hit(input logic [8:0] pos,
                                      input logic [7:0] asg,
                                      input logic       non_del);
        logic [5:0] want;
        want     = non_del ? 6'h00 : asg[5:0];
        slot_hit = asg[`CCS_SL_EN] && (pos[8:3] == want);
    endfunction : slot_hit

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [13:0] s1_reg;
    logic [13:0] s2_reg;
    logic [13:0] s3_reg;
    wire  [13:0] raw = {I_LATCH_PIN, I_RX_PCM_IN_1, I_RX_PCM_IN_0,
                        I_RX_FRAME_SYNC, I_TX_FRAME_SYNC, I_BCLK,
                        I_CI, I_CS_N, I_CTRL_CLOCK};

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            s1_reg <= `CCS_SYNC_RST;
            s2_reg <= `CCS_SYNC_RST;
            s3_reg <= `CCS_SYNC_RST;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    wire cs_n      = s2_reg[`CCS_SY_CS];
    wire ci        = s2_reg[`CCS_SY_CI];
    wire cs_rise   = s2_reg[`CCS_SY_CS] & ~s3_reg[`CCS_SY_CS];
    wire ctrl_clock_fall = ~s2_reg[`CCS_SY_CTRL_CLOCK] & s3_reg[`CCS_SY_CTRL_CLOCK];
    wire ctrl_clock_rise = s2_reg[`CCS_SY_CTRL_CLOCK] & ~s3_reg[`CCS_SY_CTRL_CLOCK];
    wire bclk_rise = s2_reg[`CCS_SY_BCLK] & ~s3_reg[`CCS_SY_BCLK];
    wire bclk_fall = ~s2_reg[`CCS_SY_BCLK] & s3_reg[`CCS_SY_BCLK];
    wire fsx_rise  = s2_reg[`CCS_SY_FSX] & ~s3_reg[`CCS_SY_FSX];
    wire fsr_rise  = s2_reg[`CCS_SY_FSR] & ~s3_reg[`CCS_SY_FSR];
    wire [5:0] lin = s2_reg[13:8];

    // ----------------------------------------
    // serial control port
    // ----------------------------------------
    ccs_pkg::ccs_cp_state_t cp_state_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] sh_in_reg;
    logic [3:0] addr_reg;
    logic       rd_reg;
    logic [7:0] out_sh_reg;
    logic       co_reg;
    logic       sleep_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] ldr_reg;
    logic [7:0] ilr_reg;
    logic [7:0] tx_gain_reg;
    logic [7:0] rx_gain_reg;
    logic [7:0] tx_wr_reg;
    logic [7:0] rx_wr_reg;
    logic [7:0] rx_code_reg;

    wire [7:0] byte_in   = {sh_in_reg[6:0], ci};
    wire       in_b2     = (cp_state_reg == ccs_pkg::CP_BYTE2);
    wire       byte_done = ctrl_clock_fall & ~cs_n & (bit_cnt_reg == `CCS_BIT_LAST);
    wire       b1_done   = byte_done & ~in_b2;
    wire       b1_two    = b1_done & byte_in[`CCS_B1_TWO];
    wire [3:0] b1_addr   = byte_in[6:3];
    wire       wr_stb    = byte_done & in_b2 & ~rd_reg;
    wire       wr_ctrl   = wr_stb & (addr_reg == `CCS_ADDR_CTRL);
    wire       wr_ldr    = wr_stb & (addr_reg == `CCS_ADDR_LDR);
    wire       wr_ilr    = wr_stb & (addr_reg == `CCS_ADDR_ILR);
    wire       wr_txg    = wr_stb & (addr_reg == `CCS_ADDR_TXGAIN);
    wire       wr_rxg    = wr_stb & (addr_reg == `CCS_ADDR_RXGAIN);
    wire       wr_txs    = wr_stb & (addr_reg == `CCS_ADDR_TXSLOT);
    wire       wr_rxs    = wr_stb & (addr_reg == `CCS_ADDR_RXSLOT);

    // latch pins and mixed readback
    logic [7:0] latch_rd;
    assign latch_rd[1:0] = 2'h0;
    genvar k;
    generate
        for (k = 0; k < 6; k++) begin : g_latch
            assign O_LATCH_PIN[k]  = ilr_reg[7-k];
            assign O_LATCH_OE[k]   = ldr_reg[7-k];
            assign latch_rd[7-k]   = ldr_reg[7-k] ? ilr_reg[7-k]
                                                  : lin[k];
        end
    endgenerate

    wire [7:0] rd_mux =
        (b1_addr == `CCS_ADDR_CTRL)   ? ctrl_reg    :
        (b1_addr == `CCS_ADDR_LDR)    ? ldr_reg     :
        (b1_addr == `CCS_ADDR_ILR)    ? latch_rd    :
        (b1_addr == `CCS_ADDR_TXGAIN) ? tx_gain_reg :
        (b1_addr == `CCS_ADDR_RXGAIN) ? rx_gain_reg :
        (b1_addr == `CCS_ADDR_TXSLOT) ? tx_wr_reg   :
        (b1_addr == `CCS_ADDR_RXSLOT) ? rx_wr_reg   : `CCS_ZERO_RST;

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cp_state_reg <= ccs_pkg::CP_BYTE1;
            bit_cnt_reg  <= `CCS_BIT_FIRST;
            sh_in_reg    <= `CCS_ZERO_RST;
            addr_reg     <= `CCS_ADDR_CTRL;
            rd_reg       <= 1'b0;
            out_sh_reg   <= `CCS_ZERO_RST;
            co_reg       <= 1'b0;
            sleep_reg    <= 1'b1;
        end else begin
            if (cs_n)
                bit_cnt_reg <= `CCS_BIT_FIRST;
            else if (ctrl_clock_fall)
                bit_cnt_reg <= 3'(bit_cnt_reg + 3'h1);
            if (ctrl_clock_fall & ~cs_n)
                sh_in_reg <= byte_in;
            if (b1_done)
                sleep_reg <= byte_in[`CCS_B1_PWR];
            case (cp_state_reg)
                ccs_pkg::CP_BYTE1: begin
                    if (b1_two) begin
                        cp_state_reg <= ccs_pkg::CP_BYTE2;
                        addr_reg     <= b1_addr;
                        rd_reg       <= byte_in[`CCS_B1_RD];
                        out_sh_reg   <= rd_mux;
                    end
                end
                ccs_pkg::CP_BYTE2: begin
                    if (byte_done)
                        cp_state_reg <= ccs_pkg::CP_BYTE1;
                    if (ctrl_clock_rise & ~cs_n & rd_reg) begin
                        co_reg     <= out_sh_reg[7];
                        out_sh_reg <= {out_sh_reg[6:0], 1'b0};
                    end
                end
                default: cp_state_reg <= ccs_pkg::CP_BYTE1;
            endcase
        end
    end

    assign O_CO    = co_reg;
    assign O_CO_OE = ~cs_n & in_b2 & rd_reg;

    // ----------------------------------------
    // programmable registers
    // ----------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ctrl_reg    <= `CCS_CTRL_RST;
            ldr_reg     <= `CCS_ZERO_RST;
            ilr_reg     <= `CCS_ZERO_RST;
            tx_gain_reg <= `CCS_ZERO_RST;
            rx_gain_reg <= `CCS_ZERO_RST;
        end else begin
            if (wr_ctrl)
                ctrl_reg <= byte_in;
            if (wr_ldr)
                ldr_reg <= byte_in & `CCS_LATCH_MASK;
            if (wr_ilr)
                ilr_reg <= byte_in & `CCS_LATCH_MASK;
            if (wr_txg)
                tx_gain_reg <= byte_in;
            if (wr_rxg)
                rx_gain_reg <= byte_in;
        end
    end

    // ----------------------------------------
    // control decode
    // ----------------------------------------
    wire law_a   = ctrl_reg[`CCS_CT_LAW];
    wire no_inv  = ctrl_reg[`CCS_CT_INV];
    wire non_del = ctrl_reg[`CCS_CT_TIM];
    wire loop_dl = ctrl_reg[`CCS_CT_DL];

    assign O_MCLK_DIV = (ctrl_reg[7:6] == 2'h0) ? `CCS_DIV_512K :
                        (ctrl_reg[7:6] == 2'h1) ? `CCS_DIV_1M5  :
                        (ctrl_reg[7:6] == 2'h2) ? `CCS_DIV_2M0  :
                                                  `CCS_DIV_4M0;
    assign O_LAW_A          = law_a;
    assign O_EVEN_INVERT    = law_a & ~no_inv;
    assign O_FULL_POS = ~law_a ? `CCS_MU_POS :
                        no_inv ? `CCS_AN_POS : `CCS_AI_POS;
    assign O_FULL_NEG = ~law_a ? `CCS_MU_NEG :
                        no_inv ? `CCS_AN_NEG : `CCS_AI_NEG;
    assign O_TIMING_DELAYED = ~non_del;
    assign O_LOOP_DIGITAL   = loop_dl;
    assign O_LOOP_WAVE_PATH = ~loop_dl & ctrl_reg[`CCS_CT_AL];
    assign O_SLEEP_STATE    = sleep_reg;
    assign O_AMP_ON = ~(sleep_reg & ctrl_reg[`CCS_CT_PP]);
    // decoding never stops in loopback; only gain zero mutes
    assign O_RX_ANALOG_MUTE = (rx_gain_reg == `CCS_ZERO_RST);
    assign O_TX_GAIN        = tx_gain_reg;

    // ----------------------------------------
    // slot assignment staging
    // ----------------------------------------
    logic [7:0] tx_act_reg;
    logic [7:0] rx_act_reg;
    logic       tx_arm_reg;
    logic       rx_arm_reg;
    logic [1:0] tx_cnt_reg;
    logic [1:0] rx_cnt_reg;

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            tx_wr_reg  <= `CCS_ZERO_RST;
            rx_wr_reg  <= `CCS_ZERO_RST;
            tx_act_reg <= `CCS_ZERO_RST;
            rx_act_reg <= `CCS_ZERO_RST;
            tx_arm_reg <= 1'b0;
            rx_arm_reg <= 1'b0;
            tx_cnt_reg <= 2'h0;
            rx_cnt_reg <= 2'h0;
        end else begin
            if (wr_txs) begin
                tx_wr_reg  <= byte_in;
                tx_arm_reg <= 1'b1;
            end else if (cs_rise & tx_arm_reg) begin
                tx_arm_reg <= 1'b0;
                tx_cnt_reg <= `CCS_FRAME_WAIT;
            end else if (fsx_rise & (tx_cnt_reg != 2'h0)) begin
                tx_cnt_reg <= 2'(tx_cnt_reg - 2'h1);
                if (tx_cnt_reg == 2'h1)
                    tx_act_reg <= tx_wr_reg;
            end
            if (wr_rxs) begin
                rx_wr_reg  <= byte_in;
                rx_arm_reg <= 1'b1;
            end else if (cs_rise & rx_arm_reg) begin
                rx_arm_reg <= 1'b0;
                rx_cnt_reg <= `CCS_FRAME_WAIT;
            end else if (fsr_rise & (rx_cnt_reg != 2'h0)) begin
                rx_cnt_reg <= 2'(rx_cnt_reg - 2'h1);
                if (rx_cnt_reg == 2'h1)
                    rx_act_reg <= rx_wr_reg;
            end
        end
    end

    // ----------------------------------------
    // PCM highway, independent tx and rx frames
    // ----------------------------------------
    logic [8:0] tx_pos_reg;
    logic [8:0] rx_pos_reg;
    logic       tx_step_reg;
    logic       tx_on_reg;
    logic [7:0] tx_sh_reg;
    logic [7:0] rx_sh_reg;
    logic       rx_valid_reg;

    // fixed slot 0 unless delayed timing selected
    wire tx_hit = slot_hit(tx_pos_reg, tx_act_reg, non_del);
    wire rx_hit = slot_hit(rx_pos_reg, rx_act_reg, non_del);
    wire rx_bit = rx_act_reg[`CCS_SL_PS] ? s2_reg[`CCS_SY_DR1]
                                         : s2_reg[`CCS_SY_DR0];
    wire [7:0] rx_byte = {rx_sh_reg[6:0], rx_bit};
    wire [7:0] tx_src  = loop_dl ? rx_code_reg : I_TX_CODE;
    wire tx_slot_go = tx_step_reg & (tx_pos_reg[2:0] == `CCS_BIT_FIRST);

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            tx_pos_reg   <= `CCS_POS_START;
            rx_pos_reg   <= `CCS_POS_START;
            tx_step_reg  <= 1'b0;
            tx_on_reg    <= 1'b0;
            tx_sh_reg    <= `CCS_ZERO_RST;
            rx_sh_reg    <= `CCS_ZERO_RST;
            rx_code_reg  <= `CCS_ZERO_RST;
            rx_valid_reg <= 1'b0;
        end else begin
            // each counter restarts on its own sync
            if (fsx_rise)
                tx_pos_reg <= `CCS_POS_START;
            else if (bclk_rise)
                tx_pos_reg <= 9'(tx_pos_reg + 9'h001);
            if (fsr_rise)
                rx_pos_reg <= `CCS_POS_START;
            else if (bclk_rise)
                rx_pos_reg <= 9'(rx_pos_reg + 9'h001);
            tx_step_reg <= bclk_rise;
            if (tx_slot_go) begin
                tx_on_reg <= tx_hit & ~sleep_reg;
                tx_sh_reg <= tx_src;
            end else if (tx_step_reg) begin
                tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            end
            rx_valid_reg <= 1'b0;
            if (bclk_fall & rx_hit) begin
                rx_sh_reg <= rx_byte;
                if (rx_pos_reg[2:0] == `CCS_BIT_LAST) begin
                    rx_code_reg  <= rx_byte;
                    rx_valid_reg <= 1'b1;
                end
            end
        end
    end

    assign O_TX_PCM_OUT_0  = tx_sh_reg[7];
    assign O_TX_PCM_OUT_1  = tx_sh_reg[7];
    assign O_TX_PCM_OE_0   = tx_on_reg & ~tx_act_reg[`CCS_SL_PS];
    assign O_TX_PCM_OE_1   = tx_on_reg & tx_act_reg[`CCS_SL_PS];
    assign O_RX_CODE       = rx_code_reg;
    assign O_RX_CODE_VALID = rx_valid_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    co_drive_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_CO_OE && !ctrl_clock_rise |=> $stable(O_CO))
        else $error("control output moved off a clock rise");
    port_excl_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        !(O_TX_PCM_OE_0 && O_TX_PCM_OE_1))
        else $error("both transmit ports enabled");
    slot_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        $changed(tx_act_reg) |-> $past(fsx_rise) && $past(tx_cnt_reg) == 2'h1)
        else $error("assignment changed off frame");
    mute_code_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        wr_rxg && byte_in == 8'h00 |=> O_RX_ANALOG_MUTE)
        else $error("zero gain did not mute");
    loop_src_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        tx_slot_go && loop_dl |=> tx_sh_reg == $past(rx_code_reg))
        else $error("loopback byte not sent");
    latch_dir_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        wr_ldr |=> O_LATCH_OE[0] == $past(byte_in[7])
                   && O_LATCH_OE[5] == $past(byte_in[2]))
        else $error("latch direction order wrong");
    ctrl_wr_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        wr_ctrl |=> ctrl_reg == $past(byte_in) && !in_b2)
        else $error("control byte not stored");
    slot_num_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        $rose(tx_on_reg) && !non_del |-> tx_pos_reg[8:3] == tx_act_reg[5:0])
        else $error("transmit in wrong slot");
endmodule : ccs_codec_config
`default_nettype wire

// >>> ccs_far_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// pcm highway: bit clock, frame sync, rx data
// ----------------------------------------
module ccs_far_model (
    input  wire logic [7:0] i_rx_byte,
    output logic            o_bclk,
    output logic            o_fs,
    output logic            o_rx_bit,
    output logic      [4:0] o_pos
);
    initial begin
        o_bclk = 1'b0;
        o_fs = 1'b0;
        o_rx_bit = 1'b0;
        o_pos = 5'h1F;
        forever begin
            #40 o_bclk = 1'b1;
            o_pos = o_pos + 5'h01;
            o_rx_bit = i_rx_byte[3'h7 - o_pos[2:0]];
            #40 o_bclk = 1'b0;
            o_fs = (o_pos == 5'h1F);
        end
    end
endmodule : ccs_far_model
`default_nettype wire

// >>> tb_codec_config_and_slot_assign.sv
`include "ccs_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_codec_config_and_slot_assign;
    logic       clk, rst_n, ctrl_clock, cs_n, ci, mon, port;
    logic [5:0] lat_in;
    logic [7:0] tx_code, rx_byte, rd, v, sh;
    logic [9:0] obs, e;
    logic [1:0] slot;
    logic [9:0] exp_q[$];
    logic [9:0] div_tab [4] = '{10'h040, 10'h0C0, 10'h100, 10'h200};
    wire        co, co_oe, bclk, fs, rxb, oe0, oe1, d0, d1, sleep;
    wire        law, inv, tdel, ldig, lwave;
    wire  [5:0] lat_out, lat_oe;
    wire        amp, mute, rxv;
    wire  [7:0] txg, rxc, fpos, fneg;
    logic [15:0] ob;
    logic       rxv_seen;
    wire  [9:0] div;
    wire  [4:0] pos;
    int         num_errors, check_count, cyc, k, n;
    event       obs_ev;
    ccs_far_model far (.i_rx_byte(rx_byte), .o_bclk(bclk), .o_fs(fs),
        .o_rx_bit(rxb), .o_pos(pos));
    ccs_codec_config dut (.I_CLK(clk), .I_RST_N(rst_n), .I_CTRL_CLOCK(ctrl_clock),
        .I_CS_N(cs_n), .I_CI(ci), .O_CO(co), .O_CO_OE(co_oe), .I_BCLK(bclk),
        .I_TX_FRAME_SYNC(fs), .I_RX_FRAME_SYNC(fs), .I_RX_PCM_IN_0(rxb),
        .I_RX_PCM_IN_1(~rxb), .O_TX_PCM_OUT_0(d0), .O_TX_PCM_OUT_1(d1),
        .O_TX_PCM_OE_0(oe0), .O_TX_PCM_OE_1(oe1), .I_LATCH_PIN(lat_in),
        .O_LATCH_PIN(lat_out), .O_LATCH_OE(lat_oe), .I_TX_CODE(tx_code),
        .O_RX_CODE(rxc), .O_RX_CODE_VALID(rxv), .O_SLEEP_STATE(sleep),
        .O_AMP_ON(amp), .O_MCLK_DIV(div), .O_LAW_A(law), .O_EVEN_INVERT(inv),
        .O_TIMING_DELAYED(tdel), .O_LOOP_DIGITAL(ldig),
        .O_LOOP_WAVE_PATH(lwave), .O_RX_ANALOG_MUTE(mute), .O_TX_GAIN(txg),
        .O_FULL_POS(fpos), .O_FULL_NEG(fneg));
    // ----------------------------------------
    // clock, timeout, result watcher
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            complete_run();
        end
    end
    always @(obs_ev) begin
        check_count++;
        if (exp_q.size() == 0 || exp_q[0] !== obs) begin
            num_errors++;
            $display("[ERR] %0t result %h not as noted", $time, obs);
        end
        if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
    always @(negedge clk) if (rxv) rxv_seen = 1'b1;
    always @(negedge bclk) begin
        if (mon && (n != 0 || pos[2:0] == 3'h0) && (port ? oe1 : oe0)) begin
            if (n == 0) slot = pos[4:3];
            sh = {sh[6:0], port ? d1 : d0};
            n++;
            if (n == 8) begin
                n = 0;
                mon = 1'b0;
                got({slot, sh});
            end
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic got(input logic [9:0] g);
        obs = g;
        ->obs_ev;
        #1;
    endtask : got
    task automatic see(input logic [9:0] x, input logic [9:0] g);
        exp_q.push_back(x);
        got(g);
    endtask : see
    task automatic xfer(input logic [15:0] w);
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            ci = w[i];
            ctrl_clock = 1'b1;
            repeat (8) @(negedge clk);
            rd = {rd[6:0], co};
            ob = {ob[14:0], co_oe};
            ctrl_clock = 1'b0;
            repeat (8) @(negedge clk);
        end
        cs_n = 1'b1;
        repeat (12) @(negedge clk);
    endtask : xfer
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        xfer({1'b0, a, 3'b010, d});
    endtask : wr
    task automatic rdreg(input logic [3:0] a);
        xfer({1'b0, a, 3'b110, 8'h00});
    endtask : rdreg
    task automatic pcm(input logic [9:0] x);
        repeat (2) @(posedge fs);
        @(negedge clk);
        exp_q.push_back(x);
        mon = 1'b1;
        for (int i = 0; i < 4000 && mon; i++) @(negedge clk);
        if (mon) got(10'h3FF);
        mon = 1'b0;
    endtask : pcm
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst_n, ctrl_clock, ci, mon, port, tx_code, rx_byte, n, rxv_seen} = '0;
        cs_n = 1'b1;
        lat_in = 6'h15;
        void'($urandom(56165));
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        see(10'h000, {4'h0, lat_oe});
        see(10'h001, {9'h0, mute});
        rdreg(`CCS_ADDR_CTRL);
        see(10'h009, {2'h0, rd});
        see(10'h0FF, ob[9:0]);
        rdreg(`CCS_ADDR_TXSLOT);
        see(10'h000, {2'h0, rd});
        for (k = 0; k < 4; k++) begin
            v = {k[1:0], 6'($urandom)};
            wr(`CCS_ADDR_CTRL, v);
            see(div_tab[k], div);
            e = {5'h0, v[5], v[5] & ~v[4], ~v[3], v[2], ~v[2] & v[1]};
            see(e, {5'h0, law, inv, tdel, ldig, lwave});
            e = {2'h0, (!v[5] ? `CCS_MU_POS :
                        v[4]  ? `CCS_AN_POS : `CCS_AI_POS)};
            see(e, {2'h0, fpos});
            e = {2'h0, (!v[5] ? `CCS_MU_NEG :
                        v[4]  ? `CCS_AN_NEG : `CCS_AI_NEG)};
            see(e, {2'h0, fneg});
            rdreg(`CCS_ADDR_CTRL);
            see({2'h0, v}, {2'h0, rd});
        end
        see(10'h000, {9'h0, sleep});
        see(10'h001, {9'h0, amp});
        xfer(16'h8080);
        see(10'h001, {9'h0, sleep});
        see({9'h0, ~v[0]}, {9'h0, amp});
        wr(`CCS_ADDR_ILR, 8'hA7);
        wr(`CCS_ADDR_LDR, 8'hF3);
        see(10'h000, ob[9:0]);
        see(10'h025, {4'h0, lat_out});
        see(10'h00F, {4'h0, lat_oe});
        rdreg(`CCS_ADDR_ILR);
        see(10'h0A8, {2'h0, rd});
        rdreg(`CCS_ADDR_LDR);
        see(10'h0F0, {2'h0, rd});
        v = 8'($urandom) | 8'h01;
        wr(`CCS_ADDR_TXGAIN, v);
        see({2'h0, v}, {2'h0, txg});
        rdreg(`CCS_ADDR_TXGAIN);
        see({2'h0, v}, {2'h0, rd});
        wr(`CCS_ADDR_RXGAIN, v);
        see(10'h000, {9'h0, mute});
        wr(`CCS_ADDR_RXGAIN, 8'h00);
        see(10'h001, {9'h0, mute});
        @(negedge clk);
        tx_code = 8'($urandom);
        rx_byte = 8'($urandom);
        port = 1'b1;
        wr(`CCS_ADDR_CTRL, 8'h01);
        wr(`CCS_ADDR_TXSLOT, 8'hC2);
        pcm({2'h2, tx_code});
        wr(`CCS_ADDR_RXSLOT, 8'h81);
        wr(`CCS_ADDR_CTRL, 8'h05);
        pcm({2'h2, rx_byte});
        see({2'h0, rx_byte}, {2'h0, rxc});
        see(10'h001, {9'h0, rxv_seen});
        wr(`CCS_ADDR_RXSLOT, 8'hC1);
        pcm({2'h2, ~rx_byte});
        port = 1'b0;
        wr(`CCS_ADDR_CTRL, 8'h09);
        wr(`CCS_ADDR_TXSLOT, 8'h82);
        pcm({2'h0, tx_code});
        complete_run();
    end
endmodule : tb_codec_config_and_slot_assign
`default_nettype wire
